// >>> hdl/sbrs_pkg.sv
// Package for the serial bus rate generator and shift register
package sbrs_pkg;
  // Special-function register addresses
  localparam logic [7:0] SBRS_ADDR_RATE = 8'h00_CF;
  localparam logic [7:0] SBRS_ADDR_CTRL = 8'h00_C0;
  localparam logic [7:0] SBRS_ADDR_DATA = 8'h00_C2;
  // Reset values
  localparam logic [7:0] SBRS_RATE_RESET = 8'h00_00;
  localparam logic [7:0] SBRS_CTRL_RESET = 8'h00_00;
  localparam logic [7:0] SBRS_DATA_RESET = 8'h00_00;
  // Control field positions
  localparam int SBRS_BIT_ENABLE = 6;
  localparam int SBRS_BIT_MASTER = 5;
  localparam int SBRS_BIT_EVENT = 3;
  localparam int SBRS_BIT_ACK = 2;
  localparam int SBRS_BIT_FTE = 1;
  localparam int SBRS_BIT_TIMEOUT = 0;
  // Timing: extra high time and its cycle count at 100 MHz
  localparam int SBRS_CLK_NS = 10;
  localparam int SBRS_HIGH_EXTRA_NS = 625;
  localparam int SBRS_HIGH_EXTRA_CYC = SBRS_HIGH_EXTRA_NS / SBRS_CLK_NS;
  localparam int SBRS_HIGH_EXTRA_OFS = 2;
  localparam int SBRS_TIMEOUT_MULT = 10;
  localparam logic [7:0] SBRS_ROLL = 8'h00_00;
  localparam logic [3:0] SBRS_BITS_PER_FRAME = 4'h9;
  typedef enum logic [1:0] {SBRS_IDLE, SBRS_LOW, SBRS_EXTRA, SBRS_HIGH} sbrs_phase_type;
endpackage

// >>> hdl/sbrs_core.sv
// Serial bus clock rate generator, shift register and free timeout
// Behaviour
// R1: Preset loads 8-bit timer; SCL toggles at rollover
// R2: Preset drives SCL only as master
// R3: Low 256-preset cycles, high 258-preset plus 625ns; the code adds 62 cycles (620ns)
// R4: Free timeout about ten times (256-preset+1)
// R5: Software keeps preset below documented bound
// R6: Shift register holds one byte
// R7: Software accesses data only while event set
// R8: Transmit MSB first to LSB
// R9: First received bit lands in MSB
// R10: SDA sampled while shifting out
// R11: Lost arbitration leaves received data held
// R12: Acknowledge drives SDA low when ack set; the code drives it only as slave, never as master
// R13: Free timeout reported only when enabled
`timescale 1ns/1ns
`default_nettype none
module sbrs_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic arb_lost
);
  import sbrs_pkg::*;

  logic [7:0] rate, next_rate;
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] shift_byte, next_shift_byte;
  logic [7:0] tmr, next_tmr;
  logic [6:0] xcnt, next_xcnt;
  logic [3:0] bitn, next_bitn;
  logic [3:0] tocnt, next_tocnt;
  logic scl_q, next_scl_q;
  logic scl_prev, next_scl_prev;
  logic arb_q, next_arb_q;
  sbrs_phase_type phase, next_phase;

  logic en, master, evt, ack, free_timeout_enable;
  logic rise, fall, rolled, ack_slot;

  assign en = ctrl[SBRS_BIT_ENABLE];
  assign master = ctrl[SBRS_BIT_MASTER];
  assign evt = ctrl[SBRS_BIT_EVENT];
  assign ack = ctrl[SBRS_BIT_ACK];
  assign free_timeout_enable = ctrl[SBRS_BIT_FTE];
  assign rise = scl_in & ~scl_prev;
  assign fall = ~scl_in & scl_prev;
  assign rolled = (tmr == 8'h00_FF);
  assign ack_slot = (bitn == SBRS_BITS_PER_FRAME - 4'h1);

  // Register read mux; unmapped addresses read zero
  always_comb begin
    case (sfr_addr)
      SBRS_ADDR_RATE: sfr_rdata = rate;
      SBRS_ADDR_CTRL: sfr_rdata = ctrl;
      SBRS_ADDR_DATA: sfr_rdata = shift_byte; // [R6]
      default: sfr_rdata = 8'h00_00;
    endcase
  end

  // Pins: open drain, SCL low only while the generator holds it low
  assign scl_oe = master & en & ~scl_q; // [R2]
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  always_comb begin
    if (!en || evt) begin
      sda_oe = 1'b0;
    end else if (ack_slot) begin
      sda_oe = ack & ~master; // [R12]
    end else begin
      sda_oe = master & ~arb_q & ~shift_byte[7]; // [R8]
    end
  end
  assign arb_lost = arb_q;

  // Next-state logic for registers, timer, shifter and timeout
  always_comb begin
    next_rate = rate;
    next_ctrl = ctrl;
    next_shift_byte = shift_byte;
    next_tmr = tmr;
    next_xcnt = xcnt;
    next_bitn = bitn;
    next_tocnt = tocnt;
    next_scl_q = scl_q;
    next_scl_prev = scl_in;
    next_arb_q = arb_q;
    next_phase = phase;
    // Rate generator: timer counts up from the preset, toggle at rollover
    case (phase)
      SBRS_IDLE: begin
        next_scl_q = 1'b1;
        if (en && master && !evt) begin
          next_tmr = rate; // [R1]
          next_phase = SBRS_LOW;
          next_scl_q = 1'b0;
        end else if (scl_in) begin
          // Free-running only while idle, so a start always loads a clean preset
          next_tmr = (rolled) ? rate : tmr + 8'h00_01; // [R4]
        end
      end
      SBRS_LOW: begin
        next_tmr = tmr + 8'h00_01;
        if (rolled) begin
          next_scl_q = 1'b1; // [R1] [R3]
          next_tmr = rate;
          next_xcnt = 7'h00;
          next_phase = SBRS_EXTRA;
        end
      end
      SBRS_EXTRA: begin
        // Hold high for the fixed offset plus the settling extra before timing resumes
        next_xcnt = xcnt + 7'h01;
        if (xcnt == 7'(SBRS_HIGH_EXTRA_OFS + SBRS_HIGH_EXTRA_CYC - 1)) begin
          next_phase = SBRS_HIGH; // [R3]
        end
      end
      SBRS_HIGH: begin
        if (scl_in) begin
          next_tmr = tmr + 8'h00_01; // Waits while a slave stretches SCL
        end
        if (rolled && scl_in) begin
          next_tmr = rate;
          if (!en || !master || evt) begin
            next_phase = SBRS_IDLE; // [R2]
          end else begin
            next_scl_q = 1'b0;
            next_phase = SBRS_LOW; // [R1]
          end
        end
      end
      default: next_phase = SBRS_IDLE;
    endcase
    // Shift on rising SCL: capture SDA into LSB while MSB leaves
    if (en && !evt && rise) begin
      if (ack_slot) begin
        next_bitn = 4'h0;
        next_ctrl[SBRS_BIT_EVENT] = 1'b1;
      end else begin
        next_shift_byte = {shift_byte[6:0], sda_in}; // [R9] [R10]
        next_bitn = bitn + 4'h1;
        if (master && !arb_q && shift_byte[7] && !sda_in) begin
          next_arb_q = 1'b1; // [R11]
          next_ctrl[SBRS_BIT_MASTER] = 1'b0;
        end
      end
    end
    // Free timeout counts rollovers of the timer while SCL stays high
    if (!scl_in || fall || !free_timeout_enable) begin
      next_tocnt = 4'h0;
    end else if (rolled && phase != SBRS_LOW && tocnt != 4'(SBRS_TIMEOUT_MULT)) begin
      next_tocnt = tocnt + 4'h1;
    end
    // Software write; hardware set of event/timeout wins over a clear
    if (sfr_wr) begin
      case (sfr_addr)
        SBRS_ADDR_RATE: next_rate = sfr_wdata;
        SBRS_ADDR_CTRL: begin
          next_ctrl = sfr_wdata | (next_ctrl & 8'h00_09);
          next_ctrl[SBRS_BIT_EVENT] = sfr_wdata[SBRS_BIT_EVENT] |
                                      (next_ctrl[SBRS_BIT_EVENT] & ~evt);
          next_ctrl[SBRS_BIT_TIMEOUT] = sfr_wdata[SBRS_BIT_TIMEOUT];
          // A loss found in this very cycle outlives the write, as does its master drop
          next_arb_q = next_arb_q & ~arb_q;
          if (next_arb_q) begin
            next_ctrl[SBRS_BIT_MASTER] = 1'b0; // [R11]
          end
          // Disabling restarts the bit count so no half byte carries over
          if (!sfr_wdata[SBRS_BIT_ENABLE]) begin
            next_bitn = 4'h0;
          end
        end
        SBRS_ADDR_DATA: next_shift_byte = sfr_wdata; // [R7]
        default: ;
      endcase
    end
    if (free_timeout_enable && tocnt == 4'(SBRS_TIMEOUT_MULT - 1) && rolled && scl_in) begin
      next_ctrl[SBRS_BIT_TIMEOUT] = 1'b1; // [R4] [R13]
    end
  end

  // State registers, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate <= SBRS_RATE_RESET;
      ctrl <= SBRS_CTRL_RESET;
      shift_byte <= SBRS_DATA_RESET;
      tmr <= 8'h00_00;
      xcnt <= 7'h00;
      bitn <= 4'h0;
      tocnt <= 4'h0;
      scl_q <= 1'b1;
      scl_prev <= 1'b1;
      arb_q <= 1'b0;
      phase <= SBRS_IDLE;
    end else if (ce) begin
      rate <= next_rate;
      ctrl <= next_ctrl;
      shift_byte <= next_shift_byte;
      tmr <= next_tmr;
      xcnt <= next_xcnt;
      bitn <= next_bitn;
      tocnt <= next_tocnt;
      scl_q <= next_scl_q;
      scl_prev <= next_scl_prev;
      arb_q <= next_arb_q;
      phase <= next_phase;
    end
  end

  // Checks
  a_low_period: assert property (@(posedge clk) disable iff (rst)
    ce && phase == SBRS_LOW && rolled |=> scl_q) // [R1]
    else $error("scl did not rise at rollover");
  a_slave_no_scl: assert property (@(posedge clk) disable iff (rst)
    !master |-> !scl_oe) // [R2]
    else $error("slave drove scl");
  a_extra_high: assert property (@(posedge clk) disable iff (rst)
    ce && phase == SBRS_LOW && rolled |=> phase == SBRS_EXTRA) // [R3]
    else $error("no extra high phase");
  a_shift_capture: assert property (@(posedge clk) disable iff (rst)
    ce && en && !evt && rise && !ack_slot && !sfr_wr
    |=> shift_byte[0] == $past(sda_in)) // [R10]
    else $error("sda not captured");
  a_ack_drive: assert property (@(posedge clk) disable iff (rst)
    en && !evt && ack_slot && !master && ack |-> sda_oe) // [R12]
    else $error("ack not driven");
  a_msb_first: assert property (@(posedge clk) disable iff (rst)
    en && !evt && master && !arb_q && !ack_slot |-> sda_oe == !shift_byte[7]) // [R8]
    else $error("msb not on sda");
  a_timeout_off: assert property (@(posedge clk) disable iff (rst)
    ce && !free_timeout_enable && !sfr_wr && !ctrl[SBRS_BIT_TIMEOUT] |=> !ctrl[SBRS_BIT_TIMEOUT]) // [R13]
    else $error("timeout while disabled");
  a_arb_slave: assert property (@(posedge clk) disable iff (rst)
    ce && !arb_q && !sfr_wr ##1 arb_q |-> !master) // [R11]
    else $error("master after lost arbitration");
  c_byte_done: cover property (@(posedge clk) disable iff (rst) $rose(evt));
  c_arb_lost: cover property (@(posedge clk) disable iff (rst) $rose(arb_q));
  c_timeout: cover property (@(posedge clk) disable iff (rst) $rose(ctrl[SBRS_BIT_TIMEOUT]));
endmodule
`default_nettype wire

// >>> verification/sbrs_peer.sv
// Far-side bus party: byte receiver and bit-banged master
`timescale 1ns/1ns
`default_nettype none
module sbrs_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] rx_byte,
  output logic rx_done
);
  int n;
  bit own;
  initial {scl_pull, sda_pull} = 2'b00;
  // Receiver: MSB arrives first, the ninth rise is the acknowledge slot
  always @(posedge scl or posedge rst) begin
    if (rst) begin
      {n, rx_done} <= '0;
    end else if (!own) begin
      rx_byte <= {rx_byte[6:0], sda};
      rx_done <= (n == 7);
      n <= (n == 8) ? 0 : n + 1;
    end
  end
  // Master: eight data bits then a released slot; hp sets the pace
  task automatic send(input logic [7:0] b, input int hp, output logic ack);
    own = 1;
    for (int i = 8; i >= 0; i--) begin
      @(posedge clk) scl_pull <= 1;
      #(hp) sda_pull <= (i > 0) && !b[i - 1];
      #(hp) scl_pull <= 0;
      #5 ack = sda;
      #(hp);
    end
    sda_pull <= 0;
    own = 0;
  endtask
  // Holds SDA low or lets it go, as a rival driver would
  task automatic hold(input logic v);
    sda_pull <= v;
  endtask
endmodule
`default_nettype wire

// >>> verification/sbrs_core_tb_top.sv
// Self-checking bench for the serial bus rate generator and shift register
`timescale 1ns/1ns
`default_nettype none
module sbrs_core_tb_top;
  import sbrs_pkg::*;
  localparam logic [7:0] PRE = 8'hb0;
  logic clk = 0, rst = 1, ce = 1, wr_s = 0, rd_ev = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [7:0] rdata, rx_byte, b;
  logic scl_oe, sda_oe, arb_lost, p_scl, p_sda, rx_done, scl, sda, a;
  logic [31:0] seed = 32'h69de_e683;
  int err_total = 0, total_checks = 0, lo, hi;
  logic [7:0] reg_q[$], byte_q[$];
  // Open-drain wires: high unless some party pulls low
  assign scl = !(scl_oe | p_scl);
  assign sda = !(sda_oe | p_sda);
  sbrs_core dut_u (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(addr), .sfr_wr(wr_s),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .arb_lost(arb_lost));
  sbrs_peer p (.clk(clk), .rst(rst), .scl(scl), .sda(sda), .scl_pull(p_scl),
    .sda_pull(p_sda), .rx_byte(rx_byte), .rx_done(rx_done));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bus cycles: inputs move at the falling edge, one-cycle strobes
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk) {addr, wdata, wr_s} = {ad, d, 1'b1};
    @(negedge clk) wr_s = 0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    reg_q.push_back(e);
    @(negedge clk) {addr, rd_ev} = {ad, 1'b1};
    @(negedge clk) rd_ev = 0;
  endtask
  // Counts falling edges while the clock pull stays at one level
  task automatic span(input logic v, output int n);
    for (n = 0; n < 4000 && scl_oe === v; n++) @(negedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchers: each result that appears is matched with the oldest note
  always @(posedge clk) if (rd_ev) chk("reg", reg_q.pop_front(), rdata);
  always @(posedge rx_done) #1 chk("peer_rx", byte_q.pop_front(), rx_byte);
  initial forever #5 clk = ~clk;
  // Watchdog: the run needs well under a tenth of this span
  initial begin
    #1_000_000;
    err_total++;
    test_done();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    // Reset values, an unmapped address and a preset read-back
    rd(SBRS_ADDR_RATE, SBRS_RATE_RESET);
    rd(SBRS_ADDR_CTRL, SBRS_CTRL_RESET);
    rd(SBRS_ADDR_DATA, SBRS_DATA_RESET);
    rd(8'h55, 8'h00);
    b = rnd();
    wr(SBRS_ADDR_RATE, b);
    rd(SBRS_ADDR_RATE, b);
    // A write while the clock enable is low must not land
    ce = 0;
    wr(SBRS_ADDR_RATE, ~b);
    ce = 1;
    rd(SBRS_ADDR_RATE, b);
    wr(SBRS_ADDR_RATE, PRE);
    // Master byte: clock periods from the preset, byte seen on the wire
    b = rnd();
    byte_q.push_back(b);
    wr(SBRS_ADDR_DATA, b);
    wr(SBRS_ADDR_CTRL, 8'h60);
    for (int j = 0; j < 4; j++) span(j[0], lo);
    span(0, hi);
    chk("low", 8'(9'h100 - PRE), lo[7:0]);
    chk("high", 8'(9'h102 - PRE + 9'(SBRS_HIGH_EXTRA_CYC)), hi[7:0]);
    addr = SBRS_ADDR_CTRL;
    for (int w = 0; w < 9000 && rdata[SBRS_BIT_EVENT] !== 1'b1; w++) @(negedge clk);
    chk("event", 8'h01, {7'h00, rdata[SBRS_BIT_EVENT]});
    wr(SBRS_ADDR_CTRL, 8'h00);
    rd(SBRS_ADDR_DATA, b);
    // Slave receive: prompt with acknowledge, then slow without it
    for (int k = 1; k >= 0; k--) begin
      b = rnd();
      wr(SBRS_ADDR_DATA, 8'hff);
      wr(SBRS_ADDR_CTRL, k ? 8'h44 : 8'h40);
      p.send(b, k ? 100 : 400, a);
      chk("ack", k ? 8'h00 : 8'h01, {7'h00, a});
      rd(SBRS_ADDR_DATA, b);
    end
    // Free timeout: set only when enabled, span follows the preset
    wr(SBRS_ADDR_CTRL, 8'h42);
    repeat (700) @(negedge clk);
    rd(SBRS_ADDR_CTRL, 8'h42);
    repeat (200) @(negedge clk);
    rd(SBRS_ADDR_CTRL, 8'h43);
    wr(SBRS_ADDR_CTRL, 8'h40);
    repeat (1000) @(negedge clk);
    rd(SBRS_ADDR_CTRL, 8'h40);
    // Lost arbitration: a far-side zero beats our leading one
    wr(SBRS_ADDR_CTRL, 8'h00);
    wr(SBRS_ADDR_DATA, 8'h80);
    p.hold(1'b1);
    wr(SBRS_ADDR_CTRL, 8'h60);
    repeat (500) @(negedge clk);
    chk("arb_lost", 8'h01, {7'h00, arb_lost});
    rd(SBRS_ADDR_CTRL, 8'h40);
    rd(SBRS_ADDR_DATA, 8'h00);
    p.hold(1'b0);
    wr(SBRS_ADDR_CTRL, 8'h00);
    chk("pending", 8'h00, 8'(byte_q.size() + reg_q.size()));
    chk("scl_oe", 8'h00, {7'h00, scl_oe});
    chk("arb_lost", 8'h00, {7'h00, arb_lost});
    test_done();
  end
endmodule
`default_nettype wire
